// *** verilog/rsf_pkg.sv ***
// Purpose: shared constants and types of the receiver serial port
// Assumes: clk_sys at 250 MHz, link clock made by the host end
// Notes:
// Contract
// RULE1 - register select low addresses the registers
// RULE2 - fifo select low reads the receive fifo
// RULE3 - host never lowers both selects together
// RULE4 - change data on falling, sample on rising
// RULE5 - one two-way data pin, msb first
// RULE6 - direction bit, then seven address bits
// RULE7 - select low half period before direction bit
// RULE8 - half period after last fall, then release
// RULE9 - 32-byte fifo, pointer advances per byte
// RULE10 - fifo select low one period before rising
// RULE11 - 2 us after last fall before release
// RULE12 - fifo select high 4 us between bytes
// RULE13 - fifo flags re-evaluated in the high gap
// RULE14 - logic clocked from the system reference
// RULE15 - sleep: registers work, fifo not served
// RULE16 - threshold flag when level reaches threshold
// RULE17 - one data byte follows the address
// RULE18 - direction polarity parameter, high means read
`default_nettype none
package rsf_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_PERIOD_PS = 4000;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int FIFO_HOLD_US = 2;
  localparam int FIFO_GAP_US = 4;
  localparam int TM_W = 10;
  localparam logic [TM_W-1:0] HALF_CYC =
    TM_W'((SCLK_PERIOD_NS * 500 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [TM_W-1:0] FULL_CYC =
    TM_W'((SCLK_PERIOD_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [TM_W-1:0] HOLD_CYC =
    TM_W'((FIFO_HOLD_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [TM_W-1:0] GAP_CYC =
    TM_W'((FIFO_GAP_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W = 6;
  localparam int REG_NUM = 128;
  localparam logic [4:0] REG_BITS = 5'h10;
  localparam logic [4:0] FIFO_BITS = 5'h08;
  localparam logic [4:0] ADDR_END = 5'h07;
  localparam logic [4:0] DATA_END = 5'h0F;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic RW_READ = 1'b1;
  // ---------------------------------------------------------------
  // host commands
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_REG_RD = 2'h0,
    CMD_REG_WR = 2'h1,
    CMD_FIFO_RD = 2'h2
  } rsf_cmd_e;
endpackage
`default_nettype wire

// *** verilog/rsf_link_if.sv ***
// Purpose: four-wire serial link between host and receiver
// Assumes: data pin pulled high when nobody drives it
// Notes: pin level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface rsf_link_if;
  logic sclk;
  logic reg_select_n;
  logic fifo_select_n;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  assign sda = dev_sda_oe ? dev_sda_o : (host_sda_oe ? host_sda_o : 1'b1);
  modport host (
    output sclk, reg_select_n, fifo_select_n, host_sda_o, host_sda_oe,
    input sda
  );
  modport dev (
    input sclk, reg_select_n, fifo_select_n, sda,
    output dev_sda_o, dev_sda_oe
  );
endinterface
`default_nettype wire

// *** verilog/rsf_fifo.sv ***
// Purpose: synchronous byte fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: in_ready is registered so back-pressure has no comb path
`timescale 1ns/1ps
`default_nettype none
module rsf_fifo import rsf_pkg::*; #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
    logic nfull;
  } rsf_fifo_s;
  localparam rsf_fifo_s RST = '{wp: '0, rp: '0, cnt: '0, nfull: 1'b1};
  rsf_fifo_s s;
  rsf_fifo_s next_s;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign push = in_valid & s.nfull;
  assign pop = out_ready & (s.cnt != '0);

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + LW'(push) - LW'(pop);
    next_s.nfull = (next_s.cnt != LW'(D));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= RST;
    end else if (ce) begin
      s <= next_s;
      if (push) begin
        mem[s.wp] <= in_data;
      end
    end
  end

  assign in_ready = s.nfull;
  assign out_valid = (s.cnt != '0);
  assign out_data = mem[s.rp];
  assign level = s.cnt;
endmodule
`default_nettype wire

// *** verilog/rsf_dev.sv ***
// Purpose: receiver end of the serial port, register and fifo access
// Assumes: link clock idles low and only runs inside a frame
// Notes: frame logic is reset by both selects being high
`timescale 1ns/1ps
`default_nettype none
module rsf_dev import rsf_pkg::*; (
  // link
  rsf_link_if.dev lk,
  // system clock, stands for the crystal reference
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // mode and configuration
  input wire logic sleep,
  input wire logic [LVL_W-1:0] fifo_threshold,
  // received data stream
  input wire logic [BYTE_W-1:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // register writes towards the core
  output logic reg_wr_valid,
  output logic [ADDR_W-1:0] reg_wr_addr,
  output logic [BYTE_W-1:0] reg_wr_data,
  // fifo status
  output logic fifo_threshold_flag,
  output logic fifo_not_empty,
  output logic fifo_full
);
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] cnt;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] sh;
    logic [BYTE_W-1:0] tx;
    logic fv;
  } rsf_frm_s;
  typedef struct packed {
    logic ack_t;
    logic wr_t;
    logic [ADDR_W-1:0] wa;
    logic [BYTE_W-1:0] wd;
  } rsf_per_s;
  typedef struct packed {
    logic sdo;
    logic oe;
    logic started;
  } rsf_neg_s;
  typedef struct packed {
    logic [1:0] fsel_s;
    logic [2:0] ack_s;
    logic [2:0] wr_s;
    logic [BYTE_W-1:0] hold;
    logic hold_v;
    logic srv;
    logic thr_flag;
    logic nmty;
    logic full;
    logic wr_pulse;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
  } rsf_sys_s;

  rsf_frm_s f;
  rsf_frm_s next_f;
  rsf_per_s p;
  rsf_per_s next_p;
  rsf_neg_s n;
  rsf_neg_s next_n;
  rsf_sys_s s;
  rsf_sys_s next_s;
  logic [BYTE_W-1:0] shadow [REG_NUM];
  logic frame_idle;
  logic shadow_we;
  logic [BYTE_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic f_nfull;
  logic [LVL_W-1:0] f_level;
  logic [LVL_W-1:0] lvl;
  logic [LVL_W-1:0] thr;

  // ---------------------------------------------------------------
  // link side, rising edge: sample and decode
  // ---------------------------------------------------------------
  // both selects high ends any frame at once, since the clock stops
  assign frame_idle = lk.reg_select_n & lk.fifo_select_n;

  always_comb begin
    next_f = f;
    next_p = p;
    shadow_we = 1'b0;
    if (f.cnt != CNT_MAX) begin
      next_f.cnt = f.cnt + 5'h01;
    end
    next_f.sh = {f.sh[BYTE_W-2:0], lk.sda}; // RULE4 RULE5
    next_f.tx = {f.tx[BYTE_W-2:0], 1'b0}; // RULE5
    if (!lk.reg_select_n) begin // RULE1 RULE3
      if (f.cnt == 5'h00) begin
        next_f.rw = lk.sda; // RULE6
      end
      if (f.cnt == ADDR_END) begin
        next_f.addr = {f.sh[ADDR_W-2:0], lk.sda}; // RULE6
        if (f.rw == RW_READ) begin // RULE18
          next_f.tx = shadow[{f.sh[ADDR_W-2:0], lk.sda}]; // RULE17
        end
      end
      if (f.cnt == DATA_END && f.rw != RW_READ) begin // RULE17
        shadow_we = 1'b1;
        next_p.wa = f.addr;
        next_p.wd = {f.sh[BYTE_W-2:0], lk.sda};
        next_p.wr_t = ~p.wr_t;
      end
    end else if (!lk.fifo_select_n) begin // RULE2
      if (f.cnt == 5'h00) begin
        // hold byte is quiet while the select is low
        next_f.fv = s.srv; // RULE15
        // an unserved frame shifts zeros, never a stale byte
        next_f.tx = s.srv ? {s.hold[BYTE_W-2:0], 1'b0} : '0; // RULE15
      end
      if (f.cnt == ADDR_END && f.fv) begin
        next_p.ack_t = ~p.ack_t; // RULE9
      end
    end
  end

  always_ff @(posedge lk.sclk or posedge frame_idle) begin
    if (frame_idle) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // toggles must outlive the frame, so only system reset clears them
  always_ff @(posedge lk.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  always_ff @(posedge lk.sclk) begin
    if (shadow_we) begin
      shadow[f.addr] <= next_p.wd;
    end
  end

  // ---------------------------------------------------------------
  // link side, falling edge: drive the pin
  // ---------------------------------------------------------------
  always_comb begin
    next_n.sdo = f.tx[BYTE_W-1]; // RULE4 RULE5
    next_n.started = 1'b1;
    next_n.oe = 1'b0;
    if (!lk.reg_select_n && f.rw == RW_READ) begin
      next_n.oe = (f.cnt > ADDR_END) && (f.cnt <= DATA_END); // RULE17
    end else if (!lk.fifo_select_n) begin
      next_n.oe = (f.cnt <= ADDR_END);
    end
  end

  always_ff @(negedge lk.sclk or posedge frame_idle) begin
    if (frame_idle) begin
      n <= '0;
    end else begin
      n <= next_n;
    end
  end

  // first fifo bit must stand before any clock edge exists
  assign lk.dev_sda_o = n.started ? n.sdo
                                  : (s.srv & s.hold[BYTE_W-1]); // RULE10
  assign lk.dev_sda_oe = n.oe | (~lk.fifo_select_n & ~n.started);

  // ---------------------------------------------------------------
  // system side: fifo, prefetch, crossings, status
  // ---------------------------------------------------------------
  rsf_fifo #(
    .W(BYTE_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(rx_valid),
    .in_ready(f_nfull),
    .in_data(rx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .level(f_level)
  ); // RULE9

  // refill only while the select is seen high and not asleep
  assign f_ready = ~s.hold_v & s.fsel_s[1] & ~sleep & f_valid; // RULE15
  assign lvl = f_level + LVL_W'(s.hold_v);
  assign thr = (fifo_threshold == '0) ? LVL_W'(1) : fifo_threshold;

  always_comb begin
    next_s = s;
    next_s.fsel_s = {s.fsel_s[0], lk.fifo_select_n};
    next_s.ack_s = {s.ack_s[1:0], p.ack_t};
    next_s.wr_s = {s.wr_s[1:0], p.wr_t};
    next_s.wr_pulse = 1'b0;
    if (s.ack_s[2] != s.ack_s[1]) begin
      next_s.hold_v = 1'b0; // RULE9
    end
    if (f_ready) begin
      next_s.hold = f_data;
      next_s.hold_v = 1'b1;
    end
    if (s.fsel_s[1]) begin
      next_s.srv = next_s.hold_v & ~sleep; // RULE15
      next_s.thr_flag = (lvl >= thr); // RULE13 RULE16
      next_s.nmty = (lvl != '0); // RULE13
      next_s.full = ~f_nfull; // RULE13
    end
    if (s.wr_s[2] != s.wr_s[1]) begin
      next_s.wr_pulse = 1'b1;
      next_s.wr_addr = p.wa;
      next_s.wr_data = p.wd;
    end
  end

  always_ff @(posedge clk_sys) begin // RULE14
    if (sys_rst) begin
      s <= '0;
      s.fsel_s <= 2'h3;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rx_ready = f_nfull;
  assign reg_wr_valid = s.wr_pulse;
  assign reg_wr_addr = s.wr_addr;
  assign reg_wr_data = s.wr_data;
  assign fifo_threshold_flag = s.thr_flag;
  assign fifo_not_empty = s.nmty;
  assign fifo_full = s.full;
endmodule
`default_nettype wire

// *** verilog/rsf_host.sv ***
// Purpose: host end, runs register and fifo frames on the link
// Assumes: one command at a time
// Notes: link clock is divided down from clk_sys
`timescale 1ns/1ps
`default_nettype none
module rsf_host import rsf_pkg::*; (
  // link
  rsf_link_if.host lk,
  // clock
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rsf_cmd_e cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [BYTE_W-1:0] cmd_wdata,
  // response
  output logic rsp_valid,
  output logic [BYTE_W-1:0] rsp_data
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_SETUP = 6'b000010,
    H_LOW = 6'b000100,
    H_HIGH = 6'b001000,
    H_HOLD = 6'b010000,
    H_GAP = 6'b100000
  } rsf_hst_e;
  typedef struct packed {
    rsf_hst_e st;
    logic [TM_W-1:0] tm;
    logic [4:0] nb;
    logic [4:0] bits;
    logic [15:0] sh;
    rsf_cmd_e kind;
    logic [1:0] sda_s;
    logic [BYTE_W-1:0] rx;
    logic sclk;
    logic rsel_n;
    logic fsel_n;
    logic sda_o;
    logic sda_oe;
    logic rdy;
    logic rv;
    logic [BYTE_W-1:0] rd;
  } rsf_host_s;
  localparam rsf_host_s RST = '{st: H_IDLE, tm: '0, nb: '0, bits: '0,
    sh: '0, kind: CMD_REG_RD, sda_s: 2'h3, rx: '0, sclk: 1'b0,
    rsel_n: 1'b1, fsel_n: 1'b1, sda_o: 1'b0, sda_oe: 1'b0, rdy: 1'b1,
    rv: 1'b0, rd: '0};
  rsf_host_s s;
  rsf_host_s next_s;
  logic expire;
  logic is_reg;

  assign expire = (s.tm == TM_W'(1));
  assign is_reg = (s.kind != CMD_FIFO_RD);

  always_comb begin
    next_s = s;
    next_s.sda_s = {s.sda_s[0], lk.sda};
    next_s.rv = 1'b0;
    if (s.tm != '0) begin
      next_s.tm = s.tm - TM_W'(1);
    end
    case (s.st)
      H_IDLE: begin
        if (cmd_valid) begin
          next_s.kind = cmd_kind;
          next_s.rdy = 1'b0;
          next_s.nb = '0;
          next_s.sh = {(cmd_kind == CMD_REG_RD) ? RW_READ : ~RW_READ,
                       cmd_addr, cmd_wdata}; // RULE6 RULE17 RULE18
          if (cmd_kind == CMD_FIFO_RD) begin
            next_s.fsel_n = 1'b0; // RULE2
            next_s.bits = FIFO_BITS;
            next_s.tm = FULL_CYC; // RULE10
          end else begin
            next_s.rsel_n = 1'b0; // RULE1 RULE3
            next_s.bits = REG_BITS;
            next_s.tm = HALF_CYC; // RULE7
            next_s.sda_oe = 1'b1;
            next_s.sda_o = (cmd_kind == CMD_REG_RD) ? RW_READ : ~RW_READ;
          end
          next_s.st = H_SETUP;
        end
      end
      H_SETUP, H_LOW: begin
        if (expire) begin
          next_s.sclk = 1'b1;
          next_s.rx = {s.rx[BYTE_W-2:0], s.sda_s[1]}; // RULE4
          next_s.tm = HALF_CYC;
          next_s.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (expire) begin
          next_s.sclk = 1'b0;
          next_s.nb = s.nb + 5'h01;
          next_s.sh = {s.sh[14:0], 1'b0};
          if (s.nb + 5'h01 == s.bits) begin
            next_s.sda_oe = 1'b0;
            next_s.tm = is_reg ? HALF_CYC : HOLD_CYC; // RULE8 RULE11
            next_s.st = H_HOLD;
          end else begin
            // data changes only on the falling edge
            next_s.sda_o = s.sh[14]; // RULE4 RULE5
            next_s.sda_oe = is_reg && (s.kind == CMD_REG_WR ||
                                       s.nb < ADDR_END); // RULE17
            next_s.tm = HALF_CYC;
            next_s.st = H_LOW;
          end
        end
      end
      H_HOLD: begin
        if (expire) begin
          next_s.rsel_n = 1'b1;
          next_s.fsel_n = 1'b1;
          next_s.tm = is_reg ? HALF_CYC : GAP_CYC; // RULE12
          next_s.st = H_GAP;
        end
      end
      H_GAP: begin
        if (expire) begin
          next_s.rv = (s.kind != CMD_REG_WR);
          next_s.rd = s.rx;
          next_s.rdy = 1'b1;
          next_s.st = H_IDLE;
        end
      end
      default: begin
        next_s = RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign lk.sclk = s.sclk;
  assign lk.reg_select_n = s.rsel_n;
  assign lk.fifo_select_n = s.fsel_n;
  assign lk.host_sda_o = s.sda_o;
  assign lk.host_sda_oe = s.sda_oe;
  assign cmd_ready = s.rdy;
  assign rsp_valid = s.rv;
  assign rsp_data = s.rd;
endmodule
`default_nettype wire

// *** verif/rsf_link_sva.sv ***
// Purpose: protocol checker on the link between host and receiver ends
// Assumes: sampled on clk_sys, link clock far slower than clk_sys
// Notes: counters measure setup, hold and gap in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module rsf_link_sva import rsf_pkg::*; (
  // clock
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link
  input wire logic sclk,
  input wire logic reg_select_n,
  input wire logic fifo_select_n,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic idle;
  logic sclk_q;
  logic [11:0] sel_cnt;
  logic [11:0] fall_cnt;
  logic [11:0] hi_cnt;
  logic [5:0] rise_cnt;
  assign idle = reg_select_n & fifo_select_n;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      sel_cnt <= 12'h000;
      fall_cnt <= 12'h000;
      hi_cnt <= 12'hFFF;
      rise_cnt <= 6'h00;
    end else begin
      sclk_q <= sclk;
      sel_cnt <= idle ? 12'h000 : sel_cnt + 12'h001;
      // saturate so a long idle never wraps into a short one
      if (sclk_q & ~sclk) fall_cnt <= 12'h000;
      else if (fall_cnt != 12'hFFF) fall_cnt <= fall_cnt + 12'h001;
      if (!fifo_select_n) hi_cnt <= 12'h000;
      else if (hi_cnt != 12'hFFF) hi_cnt <= hi_cnt + 12'h001;
      rise_cnt <= idle ? 6'h00 : rise_cnt + {5'h00, ~sclk_q & sclk};
    end
  end
  // ---------------------------------------------------------------
  // frame steps
  // ---------------------------------------------------------------
  sequence first_rise;
    $rose(sclk) && rise_cnt == 6'h00;
  endsequence
  sequence reg_end;
    $rose(reg_select_n) && fifo_select_n;
  endsequence
  sequence fifo_end;
    $rose(fifo_select_n) && reg_select_n;
  endsequence
  // one cycle of slack: counters start one edge after the event
  sel_exclusive_a: assert property (reg_select_n || fifo_select_n)
    else $error("both selects low");
  clk_idle_a: assert property (idle |-> !sclk)
    else $error("link clock runs outside a frame");
  reg_setup_a: assert property (first_rise ##0 !reg_select_n |->
    sel_cnt >= 12'(HALF_CYC) - 12'h001) else $error("register setup short");
  fifo_setup_a: assert property (first_rise ##0 !fifo_select_n |->
    sel_cnt >= 12'(FULL_CYC) - 12'h001) else $error("fifo setup short");
  reg_hold_a: assert property (reg_end |->
    fall_cnt >= 12'(HALF_CYC) - 12'h001) else $error("register hold short");
  fifo_hold_a: assert property (fifo_end |->
    fall_cnt >= 12'(HOLD_CYC) - 12'h001) else $error("fifo hold short");
  fifo_gap_a: assert property ($fell(fifo_select_n) |->
    hi_cnt >= 12'(GAP_CYC) - 12'h001) else $error("fifo gap short");
  reg_bits_a: assert property (reg_end |-> rise_cnt == 6'h10)
    else $error("register frame bit count wrong");
  fifo_bits_a: assert property (fifo_end |-> rise_cnt == 6'h08)
    else $error("fifo frame bit count wrong");
  no_contend_a: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends drive the data pin");
  sda_steady_a: assert property (sclk && $past(sclk) |-> $stable(sda))
    else $error("data changed while link clock high");
  host_drive_a: assert property (host_sda_oe |-> !reg_select_n)
    else $error("host drives outside a register frame");
  dev_drive_a: assert property (dev_sda_oe |-> !idle)
    else $error("device drives while not selected");
endmodule
`default_nettype wire

// *** verif/receiver_spi_reg_fifo_port_bench.sv ***
// Purpose: host end and receiver end joined back to back
// Assumes: ce tied high, link clock made by the host end
// Notes: fifo drain dominates the run time
`timescale 1ns/1ps
`default_nettype none
module receiver_spi_reg_fifo_port_bench import rsf_pkg::*; ();
  logic clk_sys;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic sleep = 1'b0;
  logic [LVL_W-1:0] fifo_threshold = 6'h20;
  logic [BYTE_W-1:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic rx_ready;
  logic reg_wr_valid;
  logic [ADDR_W-1:0] reg_wr_addr;
  logic [BYTE_W-1:0] reg_wr_data;
  logic fifo_threshold_flag;
  logic fifo_not_empty;
  logic fifo_full;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  rsf_cmd_e cmd_kind = CMD_REG_RD;
  logic [ADDR_W-1:0] cmd_addr = 7'h00;
  logic [BYTE_W-1:0] cmd_wdata = 8'h00;
  logic rsp_valid;
  logic [BYTE_W-1:0] rsp_data;
  int errors = 0;
  int checks = 0;
  int wr_count = 0;
  logic [ADDR_W-1:0] wr_addr_seen;
  logic [BYTE_W-1:0] wr_data_seen;
  // ---------------------------------------------------------------
  // ends and checker
  // ---------------------------------------------------------------
  rsf_link_if lk ();
  rsf_host u_rsf_host (.lk(lk), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  rsf_dev u_rsf_dev (.lk(lk), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(ce), .sleep(sleep), .fifo_threshold(fifo_threshold),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .fifo_threshold_flag(fifo_threshold_flag),
    .fifo_not_empty(fifo_not_empty), .fifo_full(fifo_full));
  rsf_link_sva u_rsf_link_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sclk(lk.sclk), .reg_select_n(lk.reg_select_n),
    .fifo_select_n(lk.fifo_select_n), .host_sda_oe(lk.host_sda_oe),
    .dev_sda_oe(lk.dev_sda_oe), .sda(lk.sda));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_wr_valid === 1'b1) begin
      wr_count++;
      wr_addr_seen = reg_wr_addr;
      wr_data_seen = reg_wr_data;
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run_cmd(input rsf_cmd_e k, input logic [6:0] a,
                         input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (((k == CMD_REG_WR) ? cmd_ready : rsp_valid) !== 1'b1
                && n < 3000);
    r = rsp_data;
    if (n >= 3000) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end
    // flags settle through the synchroniser after the gap
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic push(input logic [7:0] b, output logic ok);
    int n;
    rx_data <= b;
    rx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rx_ready !== 1'b1 && n < 20);
    ok = (rx_ready === 1'b1);
    rx_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [6:0] a[3] = '{7'h00, 7'h7F, 7'h55};
    logic [7:0] d[3] = '{8'hA5, 8'h5A, 8'h01};
    logic [7:0] r;
    int base;
    for (int i = 0; i < 3; i++) begin
      run_cmd(CMD_REG_WR, a[i], d[i], r);
      chk8({1'b0, wr_addr_seen}, {1'b0, a[i]});
      chk8(wr_data_seen, d[i]);
    end
    base = wr_count;
    for (int i = 0; i < 3; i++) begin
      run_cmd(CMD_REG_RD, a[i], 8'hFF, r);
      chk8(r, d[i]);
    end
    chk8(8'(wr_count - base), 8'h00);
    $display("test t_regs done");
  endtask
  task automatic t_fifo_full();
    logic ok;
    logic [7:0] r;
    int n;
    n = 0;
    ok = 1'b1;
    while (ok && n < 40) begin
      push(8'hA0 + 8'(n), ok);
      if (ok) n++;
    end
    repeat (8) @(posedge clk_sys);
    chk8(8'(n), 8'(FIFO_DEPTH + 1));
    chk1(fifo_full, 1'b1);
    chk1(fifo_threshold_flag, 1'b1);
    chk1(fifo_not_empty, 1'b1);
    for (int i = 0; i < n; i++) begin
      run_cmd(CMD_FIFO_RD, 7'h00, 8'h00, r);
      chk8(r, 8'hA0 + 8'(i));
      if (i == 0) chk1(fifo_full, 1'b0);
      if (i == 1) chk1(fifo_threshold_flag, 1'b0);
    end
    chk1(fifo_not_empty, 1'b0);
    run_cmd(CMD_FIFO_RD, 7'h00, 8'h00, r);
    chk8(r, 8'h00);
    $display("test t_fifo_full done");
  endtask
  task automatic t_sleep();
    logic ok;
    logic [7:0] r;
    push(8'h3C, ok);
    sleep <= 1'b1;
    run_cmd(CMD_FIFO_RD, 7'h00, 8'h00, r);
    chk8(r, 8'h00);
    run_cmd(CMD_REG_WR, 7'h22, 8'h99, r);
    run_cmd(CMD_REG_RD, 7'h22, 8'h00, r);
    chk8(r, 8'h99);
    @(posedge clk_sys);
    sleep <= 1'b0;
    run_cmd(CMD_FIFO_RD, 7'h00, 8'h00, r);
    chk8(r, 8'h3C);
    $display("test t_sleep done");
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // about 72k cycles expected, limit at 90k cycles
  initial begin
    #360000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_fifo_full();
    t_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
